/* rtl/sao_consts.svh */
// Constants of the serial audio output port: offsets, fields, resets.
// Included by the package user files; definitions only.
`ifndef SAO_CONSTS_SVH
`define SAO_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave
`define SAO_OFS_CTRL 4'h0
`define SAO_OFS_FMT 4'h4
`define SAO_OFS_STAT 4'h8
`define SAO_OFS_MASK 4'hc

// Control register fields
`define SAO_CTRL_MUTE 0
`define SAO_CTRL_GPO_SEL 1
`define SAO_CTRL_RESET 2'h0

// Format register reset: slave, 64 Fs, 24 bit, left justified
`define SAO_FMT_RESET 8'h00

// Status and mask fields
`define SAO_ST_FRAME 0
`define SAO_ST_SLIP 5
`define SAO_ST_W 6
`define SAO_ST_RESET 6'h00

// Resolution codes
`define SAO_RES_24 2'h0
`define SAO_RES_20 2'h1
`define SAO_RES_16 2'h2
`define SAO_RES_DIRECT 2'h3

// Slot counts per frame half for the two bit clock rates
`define SAO_SLOTS_64FS 7'h20
`define SAO_SLOTS_128FS 7'h40

`endif

/* rtl/sao_pkg.sv */
// Types shared by the serial audio output port.
// Assumes the constants header is included where numbers are needed.
package sao_pkg;

  // Serial output format register layout
  typedef struct packed {
    logic master;      // port_master_select
    logic rate;        // bit_clock_rate_select: 0 = 64 Fs, 1 = 128 Fs
    logic [1:0] res;   // resolution_field
    logic just;        // justify_select: 1 = right justified
    logic delay;       // first_bit_delay
    logic bpol;        // bit_clock_polarity
    logic fpol;        // frame_clock_polarity
  } sao_fmt_t;

  // One decoded subframe
  typedef struct packed {
    logic [23:0] audio;
    logic v;
    logic u;
    logic c;
  } sao_chan_t;

  // One stereo frame with its block start marker
  typedef struct packed {
    sao_chan_t left;
    sao_chan_t right;
    logic blk;
  } sao_frame_t;

endpackage

/* rtl/sao_port.sv */
// Serial audio output port with AHB-Lite register slave and interrupt.
// Assumes decoded frames arrive on CLK_SYS_IN; serial clock pins are
// asynchronous and are oversampled by CLK_SYS_IN.
// What this block does
// - Master mode drives frame and bit clocks derived from recovered clock.
// - Slave bit clock may be asynchronous and bursty; edges are oversampled.
// - Right justification is refused in slave mode.
// - Mute bit silences serial data at once, no boundary wait.
// - Software sets master, rate, resolution, justify, delay, polarities.
// - Direct format sends V, U, C per subframe and a block start marker in the left one.
// - Format bit settings give left justified, I2S and right justified.
// - Block start shown on its own pin and selectably on general output.
// - Slave slip or repeat sets sticky slip flag, held until status read or a one is written to it.
`timescale 1ns/1ps
`default_nettype none
`include "sao_consts.svh"

module sao_port (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic [31:0] HRDATA_OUT,
  input wire logic SAMPLE_VALID_IN,
  input wire sao_pkg::sao_frame_t SAMPLE_IN,
  input wire logic RECOVERED_MASTER_CLOCK_IN,
  input wire logic FRAME_CLOCK_IN,
  input wire logic BIT_CLOCK_IN,
  output logic FRAME_CLOCK_OUT,
  output logic FRAME_CLOCK_OE_OUT,
  output logic BIT_CLOCK_OUT,
  output logic BIT_CLOCK_OE_OUT,
  output logic SERIAL_DATA_OUT,
  output logic BLOCK_START_OUT,
  output logic GENERAL_OUTPUT_PIN_OUT,
  output logic IRQ_OUT
);

  logic [1:0] ctrl;
  sao_pkg::sao_fmt_t fmt;
  logic [`SAO_ST_W-1:0] status;
  logic [`SAO_ST_W-1:0] mask;
  logic [`SAO_ST_W-1:0] st_set;
  logic [`SAO_ST_W-1:0] st_clr;
  logic dph_wr;
  logic [3:0] dph_addr;
  logic aph_take;
  logic aph_rd_stat;
  logic [31:0] next_rdata;

  // AHB address phase accepted only for an active transfer
  assign aph_take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  assign aph_rd_stat = aph_take & ~HWRITE_IN &
                       (HADDR_IN[3:0] == `SAO_OFS_STAT);

  // Zero wait state slave; every response OKAY
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
  end

  // Latch the address phase for the write data phase
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dph_wr <= 1'b0;
      dph_addr <= 4'h0;
    end else begin
      dph_wr <= aph_take & HWRITE_IN;
      dph_addr <= HADDR_IN[3:0];
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (HADDR_IN[3:0])
      `SAO_OFS_CTRL: next_rdata[1:0] = ctrl;
      `SAO_OFS_FMT: next_rdata[7:0] = fmt;
      `SAO_OFS_STAT: next_rdata[`SAO_ST_W-1:0] = status;
      `SAO_OFS_MASK: next_rdata[`SAO_ST_W-1:0] = mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered in address phase, valid through the data phase
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      HRDATA_OUT <= 32'h0000_0000;
    end else if (aph_take & ~HWRITE_IN) begin
      HRDATA_OUT <= next_rdata;
    end
  end

  // Control, format and mask registers written in the data phase
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl <= `SAO_CTRL_RESET;
      fmt <= `SAO_FMT_RESET;
      mask <= `SAO_ST_RESET;
    end else if (dph_wr) begin
      case (dph_addr)
        `SAO_OFS_CTRL: ctrl <= HWDATA_IN[1:0];
        `SAO_OFS_FMT: fmt <= HWDATA_IN[7:0];
        `SAO_OFS_MASK: mask <= HWDATA_IN[`SAO_ST_W-1:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Status clears: write one, and slip also clears when status is read
  always_comb begin
    st_clr = '0;
    if (dph_wr && dph_addr == `SAO_OFS_STAT) begin
      st_clr = HWDATA_IN[`SAO_ST_W-1:0];
    end
    if (aph_rd_stat) begin
      st_clr[`SAO_ST_SLIP] = 1'b1;
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      status <= `SAO_ST_RESET;
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(((status & ~st_clr) | st_set) & mask);
    end
  end

  // Two-stage synchronisers plus a third stage for edge detection
  logic [2:0] mck_s;
  logic [2:0] fck_s;
  logic [2:0] bck_s;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mck_s <= 3'h0;
      fck_s <= 3'h0;
      bck_s <= 3'h0;
    end else begin
      mck_s <= {mck_s[1:0], RECOVERED_MASTER_CLOCK_IN};
      fck_s <= {fck_s[1:0], FRAME_CLOCK_IN};
      bck_s <= {bck_s[1:0], BIT_CLOCK_IN};
    end
  end

  // Master divider counts recovered clock edges, 256 per frame
  logic [7:0] mcnt;
  logic [7:0] next_mcnt;
  logic mck_rise;
  logic m_change;
  assign mck_rise = mck_s[1] & ~mck_s[2];
  assign next_mcnt = mcnt + 8'h01;
  assign m_change = mck_rise &
                    (fmt.rate ? (next_mcnt[0] == 1'b0) :
                                (next_mcnt[1:0] == 2'h0));
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mcnt <= 8'h00;
    end else if (mck_rise) begin
      mcnt <= next_mcnt;
    end
  end

  // Normalised clocks: frame high means left half, bit falls on change
  logic m_bck;
  logic m_lr;
  logic s_lr;
  logic s_change;
  assign m_bck = fmt.rate ? mcnt[0] : mcnt[1];
  assign m_lr = ~mcnt[7];
  assign s_lr = fck_s[1] ^ fmt.fpol;
  // Slave change edge is the bit clock edge opposite to sampling
  assign s_change = (bck_s[2] ^ fmt.bpol) & ~(bck_s[1] ^ fmt.bpol);

  // Pins: clocks driven only as master, released as slave
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FRAME_CLOCK_OUT <= 1'b0;
      BIT_CLOCK_OUT <= 1'b0;
      FRAME_CLOCK_OE_OUT <= 1'b0;
      BIT_CLOCK_OE_OUT <= 1'b0;
    end else begin
      FRAME_CLOCK_OUT <= m_lr ^ fmt.fpol;
      BIT_CLOCK_OUT <= m_bck ^ fmt.bpol;
      FRAME_CLOCK_OE_OUT <= fmt.master;
      BIT_CLOCK_OE_OUT <= fmt.master;
    end
  end

  logic change;
  logic lr_now;
  assign change = fmt.master ? m_change : s_change;
  assign lr_now = fmt.master ? ~next_mcnt[7] : s_lr;

  // Incoming frame held until the next left half starts
  sao_pkg::sao_frame_t pend;
  sao_pkg::sao_frame_t shadow;
  logic [1:0] upd_cnt;
  logic last_lr;
  logic [6:0] pos;
  logic left_start;
  assign left_start = change & lr_now & ~last_lr;

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pend <= '0;
    end else if (SAMPLE_VALID_IN) begin
      pend <= SAMPLE_IN;
    end
  end

  // Count frame arrivals between left starts to spot slips and repeats
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      upd_cnt <= 2'h0;
    end else if (left_start) begin
      upd_cnt <= {1'b0, SAMPLE_VALID_IN};
    end else if (SAMPLE_VALID_IN && upd_cnt != 2'h3) begin
      upd_cnt <= upd_cnt + 2'h1;
    end
  end

  // Status events: frame started, and slip in slave mode only
  always_comb begin
    st_set = '0;
    st_set[`SAO_ST_FRAME] = left_start;
    st_set[`SAO_ST_SLIP] = left_start & ~fmt.master &
                           (upd_cnt != 2'h1);
  end

  // Load shadow at left start; a missing update repeats the old frame
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      shadow <= '0;
    end else if (left_start) begin
      shadow <= pend;
    end
  end

  // Slot position within the current half, restarted on each half
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      last_lr <= 1'b0;
      pos <= 7'h00;
    end else if (change) begin
      last_lr <= lr_now;
      pos <= (lr_now != last_lr) ? 7'h00 : pos + 7'h01;
    end
  end

  // Left aligned word of the current half
  sao_pkg::sao_chan_t chan;
  logic [31:0] word;
  logic [31:0] res_mask;
  logic [6:0] width;
  logic [6:0] slots;
  logic [6:0] rj_start;
  logic [6:0] k;
  logic bit_ok;
  logic rj;
  logic next_sdata;
  assign chan = last_lr ? shadow.left : shadow.right;
  assign slots = fmt.rate ? `SAO_SLOTS_128FS : `SAO_SLOTS_64FS;
  // Right justified needs a known slot count, so slave forces left
  assign rj = fmt.just & fmt.master;

  always_comb begin
    width = 7'd24;
    res_mask = 32'hffff_ff00;
    case (fmt.res)
      `SAO_RES_24: begin
        width = 7'd24;
        res_mask = 32'hffff_ff00;
      end
      `SAO_RES_20: begin
        width = 7'd20;
        res_mask = 32'hffff_f000;
      end
      `SAO_RES_16: begin
        width = 7'd16;
        res_mask = 32'hffff_0000;
      end
      default: begin
        width = 7'd28;
        res_mask = 32'hffff_fff0;
      end
    endcase
  end

  // Direct format replaces parity with the block start marker
  always_comb begin
    if (fmt.res == `SAO_RES_DIRECT) begin
      word = {chan.audio, chan.v, chan.u, chan.c,
              shadow.blk & last_lr, 4'h0};
    end else begin
      word = {chan.audio, 8'h00} & res_mask;
    end
  end

  // Bit select: MSB first, after optional one slot delay
  always_comb begin
    rj_start = slots - width;
    if (rj) begin
      bit_ok = pos >= rj_start;
      k = pos - rj_start;
    end else begin
      bit_ok = pos >= {6'h00, fmt.delay};
      k = pos - {6'h00, fmt.delay};
    end
    if (k > 7'd31) begin
      bit_ok = 1'b0;
    end
    next_sdata = bit_ok ? word[5'd31 - k[4:0]] : 1'b0;
  end

  // Data re-evaluated every cycle so mute takes effect at once
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      SERIAL_DATA_OUT <= 1'b0;
    end else begin
      SERIAL_DATA_OUT <= next_sdata & ~ctrl[`SAO_CTRL_MUTE];
    end
  end

  // Block start shown on its pin and routed to general output when the GPO select control bit is set
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      BLOCK_START_OUT <= 1'b0;
      GENERAL_OUTPUT_PIN_OUT <= 1'b0;
    end else begin
      BLOCK_START_OUT <= shadow.blk;
      GENERAL_OUTPUT_PIN_OUT <= shadow.blk & ctrl[`SAO_CTRL_GPO_SEL];
    end
  end

  // Unused bus inputs: only whole-word singles are expected
  logic unused_ok;
  assign unused_ok = ^{HADDR_IN[31:4], HSIZE_IN, HTRANS_IN[0]};

endmodule // sao_port
`default_nettype wire

/* verification/sao_props.sv */
// Checker of the serial audio output port, bound to its top module.
// Assumes a bench master clock of about five system clocks a period.
`timescale 1ns/1ps
`default_nettype none
`include "sao_consts.svh"
module sao_props (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic FRAME_CLOCK_OUT,
  input wire logic FRAME_CLOCK_OE_OUT,
  input wire logic BIT_CLOCK_OUT,
  input wire logic BIT_CLOCK_OE_OUT,
  input wire logic SERIAL_DATA_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  logic wp;
  logic mute;
  logic msel;
  logic [3:0] wa;
  // Shadow of mute and master bits; the bus never waits, so no ready
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wp <= 1'b0;
      wa <= 4'h0;
      mute <= 1'b0;
      msel <= 1'b0;
    end else begin
      wp <= HSEL_IN & HTRANS_IN[1] & HWRITE_IN;
      wa <= HADDR_IN[3:0];
      if (wp && wa == `SAO_OFS_CTRL)
        mute <= HWDATA_IN[`SAO_CTRL_MUTE];
      if (wp && wa == `SAO_OFS_FMT)
        msel <= HWDATA_IN[7];
    end
  end
  a_ready_high: assert property (HREADYOUT_OUT)
    else $error("wait state seen");
  a_resp_okay: assert property (!HRESP_OUT)
    else $error("error response seen");
  a_oe_pair: assert property (FRAME_CLOCK_OE_OUT == BIT_CLOCK_OE_OUT)
    else $error("clock enables differ");
  a_master_drive: assert property (msel [*3] |-> BIT_CLOCK_OE_OUT)
    else $error("master not driving");
  a_slave_input: assert property (!msel [*3] |-> !FRAME_CLOCK_OE_OUT)
    else $error("slave driving clock");
  a_mute_now: assert property (mute |=> !SERIAL_DATA_OUT)
    else $error("data while muted");
  a_bit_hold: assert property (BIT_CLOCK_OE_OUT && $changed(BIT_CLOCK_OUT)
    |=> $stable(BIT_CLOCK_OUT) [*3]) else $error("bit clock too fast");
  a_frame_hold: assert property (FRAME_CLOCK_OE_OUT &&
    $changed(FRAME_CLOCK_OUT) |=> $stable(FRAME_CLOCK_OUT) [*8])
    else $error("frame clock too fast");
endmodule // sao_props
`default_nettype wire

/* verification/sao_sink.sv */
// Downstream serial receiver: clock source in slave mode, capture always.
// Assumes its clock and frame inputs are the resolved pin levels.
`timescale 1ns/1ps
`default_nettype none
module sao_sink (
  input wire logic en_in,
  input wire logic fpol_in,
  input wire logic sck_in,
  input wire logic fr_in,
  input wire logic sd_in,
  output logic sck_out,
  output logic fr_out,
  output logic [31:0] left_out,
  output logic [31:0] right_out,
  output int frames_out
);
  logic [31:0] sr = 32'h0;
  initial begin
    sck_out = 1'b1;
    fr_out = 1'b0;
    frames_out = 0;
  end
  // Frame runs on, bit clock only in bursts, idle high
  always begin
    wait (en_in);
    fr_out = ~fr_out;
    #320;
    repeat (32) begin
      sck_out = 1'b0;
      #80;
      sck_out = 1'b1;
      #80;
    end
    #320;
  end
  // Sampled on the rising edge, MSB first
  always @(posedge sck_in)
    sr <= {sr[30:0], sd_in};
  // The half that just ended is kept at each frame edge
  always @(fr_in) begin
    if (fr_in ^ fpol_in) begin
      right_out = sr;
      frames_out++;
    end else
      left_out = sr;
  end
endmodule // sao_sink
`default_nettype wire

/* verification/sao_port_bench.sv */
// Bench of the serial audio output port: bus tasks, sink, scenarios.
// Assumes the checker and sink model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "sao_consts.svh"
`define CHK(n, e, s) \
  checks_done++; \
  if ((s) !== (e)) begin \
    n_mismatch++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); \
  end
module sao_port_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic valid = 1'b0;
  logic mclk = 1'b0;
  logic en = 1'b1;
  logic fpol = 1'b0;
  logic feed = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd, hrdata, lw, rw;
  logic hrdy, hresp, fro, froe, sco, scoe, sd, blk, general_output_pin, irq, sck_m, fr_m;
  sao_pkg::sao_frame_t smp = {24'h9c35a1, 3'h5, 24'h3e0c7f, 3'h2, 1'b1};
  logic [9:0] rows [8] = '{10'h000, 10'h010, 10'h020, 10'h230, 10'h008,
    10'h005, 10'h100, 10'h2a8};
  int nfr, n_mismatch = 0, checks_done = 0;
  wire fr_w = froe ? fro : fr_m;
  wire sck_w = scoe ? sco : sck_m;
  initial forever #10 clk = ~clk;
  initial forever #53 mclk = ~mclk;
  sao_port u_dut (
    .CLK_SYS_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hrdy), .HREADYOUT_OUT(hrdy),
    .HRESP_OUT(hresp), .HRDATA_OUT(hrdata), .SAMPLE_VALID_IN(valid),
    .SAMPLE_IN(smp), .RECOVERED_MASTER_CLOCK_IN(mclk),
    .FRAME_CLOCK_IN(fr_w), .BIT_CLOCK_IN(sck_w), .FRAME_CLOCK_OUT(fro),
    .FRAME_CLOCK_OE_OUT(froe), .BIT_CLOCK_OUT(sco),
    .BIT_CLOCK_OE_OUT(scoe), .SERIAL_DATA_OUT(sd), .BLOCK_START_OUT(blk),
    .GENERAL_OUTPUT_PIN_OUT(general_output_pin), .IRQ_OUT(irq));
  sao_sink u_sink (.en_in(en), .fpol_in(fpol), .sck_in(sck_w),
    .fr_in(fr_w), .sd_in(sd), .sck_out(sck_m), .fr_out(fr_m),
    .left_out(lw), .right_out(rw), .frames_out(nfr));
  // One sample a frame, pushed at the right half so it never races a left
  always @(fr_w)
    if (feed && !(fr_w ^ fpol)) begin
      @(posedge clk);
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
    end
  task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {28'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_fr(input int n);
    int k;
    k = nfr + n;
    while (nfr < k)
      @(posedge clk);
  endtask
  function automatic logic [31:0] exp_w(input sao_pkg::sao_fmt_t f,
      input sao_pkg::sao_chan_t c, input logic z);
    logic [31:0] w;
    int n;
    n = (f.res == `SAO_RES_DIRECT) ? 28 : 24 - 4 * f.res;
    w = {c.audio, c.v, c.u, c.c, z, 4'h0} & ~(32'hffffffff >> n);
    if (f.master && f.just)
      w = w >> (32 - n);
    else if (f.delay)
      w = w >> 1;
    return w;
  endfunction
  // Status bit 0 may already be set, so status is not compared here
  task automatic reset_check;
    `CHK("hresp", 1'b0, hresp)
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, a[3:0], 32'h0);
      `CHK("reset", 32'h0, rd & (a == 8 ? 32'h0 : 32'hffffffff))
    end
  endtask
  task automatic slip_case;
    bus(1'b0, `SAO_OFS_STAT, 32'h0);
    wait_fr(2);
    bus(1'b0, `SAO_OFS_STAT, 32'h0);
    `CHK("slip", 1'b0, rd[`SAO_ST_SLIP])
    feed = 1'b0;
    wait_fr(3);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, `SAO_OFS_MASK, 32'h20);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    feed = 1'b1;
    wait_fr(2);
    bus(1'b0, `SAO_OFS_STAT, 32'h0);
    `CHK("slip", 1'b1, rd[`SAO_ST_SLIP])
    wait_fr(2);
    bus(1'b1, `SAO_OFS_STAT, 32'h21);
    bus(1'b0, `SAO_OFS_STAT, 32'h0);
    `CHK("slip", 1'b0, rd[`SAO_ST_SLIP])
    `CHK("irq", 1'b0, irq)
    bus(1'b1, `SAO_OFS_MASK, 32'h0);
  endtask
  // Row: control bits over format bits; mute row expects silence
  task automatic run_fmt(input logic [9:0] r);
    sao_pkg::sao_fmt_t f;
    f = r[7:0];
    en <= !f.master;
    fpol <= f.fpol;
    bus(1'b1, `SAO_OFS_FMT, {24'h0, f});
    bus(1'b1, `SAO_OFS_CTRL, {30'h0, r[9:8]});
    wait_fr(3);
    `CHK("oe", f.master, froe)
    `CHK("left", r[8] ? 32'h0 : exp_w(f, smp.left, smp.blk), lw)
    `CHK("right", r[8] ? 32'h0 : exp_w(f, smp.right, 1'b0), rw)
    `CHK("blk", smp.blk, blk)
    `CHK("gpo", smp.blk & r[9], general_output_pin)
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_check;
    slip_case;
    foreach (rows[i])
      run_fmt(rows[i]);
    end_sim;
  end
  // Whole run is near half a millisecond; twice that means a hang
  initial begin
    #1000000;
    n_mismatch++;
    end_sim;
  end
endmodule // sao_port_bench
bind sao_port sao_props u_props (.CLK_SYS_IN, .RST_IN, .HSEL_IN,
  .HADDR_IN, .HTRANS_IN, .HWRITE_IN, .HWDATA_IN, .HREADYOUT_OUT,
  .HRESP_OUT, .FRAME_CLOCK_OUT, .FRAME_CLOCK_OE_OUT, .BIT_CLOCK_OUT,
  .BIT_CLOCK_OE_OUT, .SERIAL_DATA_OUT);
`default_nettype wire
